// ### sim/atr_analog_model.sv
// analog core stand-in: converter clock ticks, result bus, amplifier settle glitch
`timescale 1ns/1ps
module atr_analog_model #(
    parameter int TICK_DIV = 4
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       conv_busy,
    input  wire logic [9:0] result,
    input  wire logic       glitch_req,
    output logic            adc_clk_tick,
    output logic [9:0]      conv_data,
    output logic            amp_out_changed
);
    logic [3:0] div_r;
    // prescaler runs free so the amp divider keeps its phase between conversions
    always_ff @(posedge mclk) begin
        if (!rst_n || div_r == 4'(TICK_DIV - 1)) div_r <= 4'h0;
        else div_r <= div_r + 4'h1;
    end
    assign adc_clk_tick = (div_r == 4'h0);
    // result is only held while converting; otherwise the bus shows its inverse
    assign conv_data = conv_busy ? result : ~result;
    // amplifier output moves only when the bench asks
    always_ff @(posedge mclk) amp_out_changed <= glitch_req;
endmodule

// ### sim/atr_conv_checker.sv
// checker: port-level timing relations of the converter control block
`timescale 1ns/1ps
module atr_conv_checker (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic [3:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        adc_clk_tick,
    input wire logic        amp_out_changed,
    input wire logic        reference_pin_connect,
    input wire logic [7:0]  port_read_zero,
    input wire logic [6:0]  port_read_one,
    input wire logic [14:0] input_buf_disable,
    input wire logic        conv_busy,
    input wire logic        conv_sample,
    input wire logic        amp_phase_clock
);
    logic [4:0] tk_r;
    logic [3:0] ph_r;
    logic       skip_r;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // ticks while busy; a restart or a stop write spoils the count, so skip it
    always_ff @(posedge mclk) begin
        if (!rst_n || !conv_busy) tk_r <= 5'h00;
        else tk_r <= tk_r + 5'(adc_clk_tick && (conv_sample || tk_r != 5'h00)); // wait for amp event not counted
        if (!rst_n || !conv_busy) skip_r <= 1'b0;
        else if (amp_out_changed || (reg_wr && reg_addr == atr_pkg::OFS_CTRL_A)) skip_r <= 1'b1;
    end
    // ticks between two edges of the amp phase clock
    always_ff @(posedge mclk) begin
        if (!rst_n) ph_r <= 4'h0;
        else if ($changed(amp_phase_clock)) ph_r <= 4'(adc_clk_tick);
        else ph_r <= ph_r + 4'(adc_clk_tick);
    end
    refpin_follow_a: assert property (
        reg_wr && reg_addr == atr_pkg::OFS_CTRL_B ##1 !(reg_wr && reg_addr == atr_pkg::OFS_CTRL_B)
        |-> ##1 reference_pin_connect == $past(reg_wdata[5], 2)) else $error("reference connect mismatch");
    ctrlb_bit4_a: assert property (reg_rd && reg_addr == atr_pkg::OFS_CTRL_B |=> !reg_rdata[4])
        else $error("control b bit 4 read as one");
    disone_bit7_a: assert property (reg_rd && reg_addr == atr_pkg::OFS_DIS_ONE |=> !reg_rdata[7])
        else $error("disable one bit 7 read as one");
    zero_mask_a: assert property (
        (port_read_zero & input_buf_disable[7:0] & $past(input_buf_disable[7:0])) == 8'h00)
        else $error("disabled port zero bit reads one");
    one_mask_a: assert property (
        (port_read_one & input_buf_disable[14:8] & $past(input_buf_disable[14:8])) == 7'h00)
        else $error("disabled port one bit reads one");
    sample_busy_a: assert property (conv_sample |-> conv_busy)
        else $error("sample phase outside a conversion");
    amp_div8_a: assert property ($changed(amp_phase_clock) |-> ph_r == 4'h4)
        else $error("amp phase clock is not converter clock over 8");
    conv_len_a: assert property ($fell(conv_busy) && !skip_r |-> tk_r inside {[5'd12:5'd15]})
        else $error("conversion length out of range");
    cover property ($fell(conv_busy));
    cover property (conv_sample && amp_out_changed);
    cover property ($changed(amp_phase_clock));
endmodule
bind atr_conv_ctrl atr_conv_checker i_atr_conv_checker (
    .mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .adc_clk_tick, .amp_out_changed,
    .reference_pin_connect, .port_read_zero, .port_read_one, .input_buf_disable, .conv_busy, .conv_sample,
    .amp_phase_clock
);

// ### sim/test_atr_conv_ctrl.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module test_atr_conv_ctrl;
    logic        mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, glitch_req = 1'b0;
    logic        amp_channel_sel = 1'b0, done_vector_ack = 1'b0, adc_clk_tick, amp_out_changed;
    logic        reference_pin_connect, conv_busy, conv_sample, amp_phase_clock, amp_sample_pulse;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata, port_in_zero = 8'hff, port_read_zero;
    logic [6:0]  port_in_one = 7'h7f, port_read_one;
    logic [9:0]  conv_data, result = 10'h2b7;
    logic [13:1] trig_events = 13'h0000;
    logic [2:0]  amp_sync_events = 3'h0;
    logic [14:0] input_buf_disable;
    int          error_cnt = 0, num_checks = 0, cyc = 0;
    // rows: offset, value written, value read back
    logic [19:0] rows [0:5] = '{20'h1ffef, 20'h4a5a5, 20'h5ff7f, 20'h9ff00, 20'h3ff00, 20'h68080};

    always #2 mclk = ~mclk;

    atr_conv_ctrl i_atr_conv_ctrl (
        .mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .adc_clk_tick, .trig_events,
        .amp_sync_events, .amp_channel_sel, .amp_out_changed, .conv_data, .done_vector_ack, .port_in_zero,
        .port_in_one, .reference_pin_connect, .port_read_zero, .port_read_one, .input_buf_disable,
        .conv_busy, .conv_sample, .amp_phase_clock, .amp_sample_pulse
    );
    atr_analog_model i_atr_analog_model (
        .mclk, .rst_n, .conv_busy, .result, .glitch_req, .adc_clk_tick, .conv_data, .amp_out_changed
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // read one register and compare the answer in the cycle after the strobe
    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(16'(reg_rdata), 16'(e));
    endtask
    // bounded wait for a level, so a stuck design cannot hang here
    task automatic wl(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 400) begin
            @(posedge mclk);
            #1 n++;
        end
        chk(16'(s), 16'(v));
    endtask
    task automatic fire(input int i);
        @(posedge mclk);
        trig_events[i] <= 1'b1;
        repeat (6) @(posedge mclk);
        trig_events[i] <= 1'b0;
    endtask
    task automatic conv(input logic [7:0] d);
        wr(4'h0, d);
        wl(conv_busy, 1'b1);
        wl(conv_busy, 1'b0);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // hang guard, well above the length of the whole sequence
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            $display("BAD %0t: run hung", $time);
            conclude();
        end
    end

    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        for (int a = 0; a < 16; a++) rc(4'(a), 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(rows[i][19:16], rows[i][15:8]);
            rc(rows[i][19:16], rows[i][7:0]);
        end
        chk(16'({reference_pin_connect, input_buf_disable}), 16'hffa5);
        chk({port_read_zero, 1'b0, port_read_one}, 16'h5a00);
        wl(amp_sample_pulse, 1'b1);
        $display("register rows done");
        wr(4'h1, 8'h01);
        fire(1);
        repeat (8) @(posedge mclk);
        #1 chk(16'({reference_pin_connect, conv_busy}), 16'h0000);
        conv(8'h40);
        rc(4'h0, 8'h10);
        @(posedge mclk) done_vector_ack <= 1'b1;
        @(posedge mclk) done_vector_ack <= 1'b0;
        rc(4'h0, 8'h00);
        rc(4'h2, 8'hb7);
        result <= 10'h155;
        conv(8'h40);
        rc(4'h3, 8'h02);
        rc(4'h2, 8'hb7);
        rc(4'h3, 8'h02);
        conv(8'h40);
        rc(4'h2, 8'h55);
        rc(4'h3, 8'h01);
        conv(8'h48);
        rc(4'h2, 8'h40);
        rc(4'h3, 8'h55);
        wr(4'h0, 8'h10);
        rc(4'h0, 8'h00);
        $display("single conversions done");
        for (int c = 1; c < 14; c++) begin
            wr(4'h1, 8'(c));
            wr(4'h0, 8'h20);
            fire(c);
            wl(conv_busy, 1'b1);
            wl(conv_busy, 1'b0);
        end
        wr(4'h1, 8'h0e);
        fire(2);
        fire(13);
        repeat (8) @(posedge mclk);
        #1 chk(16'(conv_busy), 16'h0000);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h60);
        wl(conv_busy, 1'b1);
        repeat (150) @(posedge mclk);
        #1 chk(16'(conv_busy), 16'h0001);
        wr(4'h0, 8'h00);
        wl(conv_busy, 1'b0);
        repeat (100) @(posedge mclk);
        #1 chk(16'(conv_busy), 16'h0000);
        $display("trigger sources done");
        @(posedge mclk) amp_channel_sel <= 1'b1;
        wr(4'h0, 8'h40);
        wl(conv_sample, 1'b1);
        @(posedge mclk) glitch_req <= 1'b1;
        repeat (3) @(posedge mclk);
        glitch_req <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk(16'(conv_sample), 16'h0001);
        wl(conv_busy, 1'b0);
        conv(8'h60);
        repeat (100) @(posedge mclk);
        #1 chk(16'(conv_busy), 16'h0000);
        wr(4'h1, 8'h01);
        fire(1);
        wl(conv_busy, 1'b1);
        wl(conv_busy, 1'b0);
        wr(4'h0, 8'h00);
        wr(4'h6, 8'h81);
        @(posedge mclk) amp_sync_events[0] <= 1'b1;
        wl(amp_sample_pulse, 1'b1);
        @(posedge mclk) amp_sync_events[0] <= 1'b0;
        $display("amplified conversions done");
        conclude();
    end
endmodule

// ### verilog/atr_conv_ctrl.sv
// converter control: trigger selection, result registers, input disable, amp sync
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module atr_conv_ctrl (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    input  wire logic        adc_clk_tick,
    input  wire logic [13:1] trig_events,
    input  wire logic [2:0]  amp_sync_events,
    input  wire logic        amp_channel_sel,
    input  wire logic        amp_out_changed,
    input  wire logic [9:0]  conv_data,
    input  wire logic        done_vector_ack,
    input  wire logic [7:0]  port_in_zero,
    input  wire logic [6:0]  port_in_one,
    output logic             reference_pin_connect,
    output logic [7:0]       port_read_zero,
    output logic [6:0]       port_read_one,
    output logic [14:0]      input_buf_disable,
    output logic             conv_busy,
    output logic             conv_sample,
    output logic             amp_phase_clock,
    output logic             amp_sample_pulse
);
    typedef enum logic [1:0] {
        ATR_IDLE   = 2'b00,
        ATR_WAIT   = 2'b01,
        ATR_SAMPLE = 2'b10,
        ATR_CONV   = 2'b11
    } atr_state_t;

    // registers
    logic [7:0]  ctrl_a_r;
    logic [7:0]  ctrl_b_r;
    logic [7:0]  dis_zero_r;
    logic [7:0]  dis_one_r;
    logic [7:0]  amp_ctrl_r;
    logic [9:0]  result_r;
    logic        lock_r;
    logic        done_r;
    logic        start_r;
    atr_state_t  state_r;
    logic [3:0]  cnt_r;
    logic [3:0]  len_r;
    logic [2:0]  div_r;
    logic        amp_sync_r;
    logic [13:0] ev_s1_r;
    logic [13:0] ev_s2_r;
    logic [13:0] ev_prev_r;
    logic [2:0]  as_s1_r;
    logic [2:0]  as_s2_r;
    logic [2:0]  as_prev_r;
    logic        trig_pend_r;
    logic [7:0]  pz_s1_r;
    logic [7:0]  pz_s2_r;
    logic [6:0]  po_s1_r;
    logic [6:0]  po_s2_r;

    logic        wr_a;
    logic        trig_hit;
    logic        amp_evt;
    logic        finish;
    logic [7:0]  res_hi;
    logic [7:0]  res_lo;
    logic [3:0]  tsel;

    // register write decode, shared by every write path
    function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] ofs, input logic w);
        wr_hit = w && (a == ofs);
    endfunction

    assign wr_a = wr_hit(reg_addr, atr_pkg::OFS_CTRL_A, reg_wr);
    assign tsel = ctrl_b_r[3:0];

    // two-flop synchronisers for event inputs from other blocks
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ev_s1_r   <= 14'h0000;
            ev_s2_r   <= 14'h0000;
            ev_prev_r <= 14'h0000;
            as_s1_r   <= 3'h0;
            as_s2_r   <= 3'h0;
            as_prev_r <= 3'h0;
        end else begin
            ev_s1_r   <= {trig_events, 1'b0};
            ev_s2_r   <= ev_s1_r;
            ev_prev_r <= ev_s2_r;
            as_s1_r   <= amp_sync_events;
            as_s2_r   <= as_s1_r;
            as_prev_r <= as_s2_r;
        end
    end

    // trigger selection; reserved codes never fire
    always_comb begin
        trig_hit = 1'b0;
        if (ctrl_a_r[atr_pkg::CA_AUTO] && tsel < atr_pkg::TRIG_COUNT) begin
            if (tsel == atr_pkg::TRIG_FREE) begin
                trig_hit = finish && !amp_channel_sel;
            end else if (tsel >= atr_pkg::TRIG_PSTAGE0 && tsel <= 4'h9) begin
                // flagless: every event, but only when nothing runs
                trig_hit = ev_s2_r[tsel] && !ev_prev_r[tsel] && state_r == ATR_IDLE;
            end else begin
                trig_hit = ev_s2_r[tsel] && !ev_prev_r[tsel];
            end
        end
    end

    // amp sync source: internal divider or external event edge
    always_comb begin
        case (amp_ctrl_r[atr_pkg::AMP_SRC_LO +: 2])
            2'b00:   amp_evt = adc_clk_tick && div_r == atr_pkg::AMP_SH_PHASE;
            2'b01:   amp_evt = as_s2_r[0] && !as_prev_r[0];
            2'b10:   amp_evt = as_s2_r[1] && !as_prev_r[1];
            2'b11:   amp_evt = as_s2_r[2] && !as_prev_r[2];
            default: amp_evt = 1'b0;
        endcase
    end

    assign finish = state_r == ATR_CONV && adc_clk_tick && cnt_r == len_r;

    // converter clock divided by 8 for the amplifier
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            div_r <= 3'h0;
        end else if (adc_clk_tick) begin
            div_r <= div_r + 3'h1;
        end
    end

    // amp sample pulse: one amplification per sync event when enabled
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            amp_sync_r <= 1'b0;
        end else begin
            amp_sync_r <= amp_evt && amp_ctrl_r[atr_pkg::AMP_EN];
        end
    end

    // pending auto trigger for amplified channel waits for next amp event
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            trig_pend_r <= 1'b0;
        end else if (trig_hit && amp_channel_sel && state_r == ATR_IDLE) begin
            trig_pend_r <= 1'b1;
        end else if (state_r != ATR_WAIT && state_r != ATR_IDLE) begin
            trig_pend_r <= 1'b0;
        end
    end

    // conversion sequencer; a busy converter refuses new starts
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_r <= ATR_IDLE;
            cnt_r   <= 4'h0;
            len_r   <= atr_pkg::CONV_CLKS;
        end else begin
            case (state_r)
                ATR_IDLE: begin
                    if (start_r || trig_hit) begin
                        cnt_r <= 4'h0;
                        len_r <= (amp_channel_sel && div_r[2]) ? atr_pkg::CONV_CLKS_HI
                                                               : atr_pkg::CONV_CLKS;
                        state_r <= (amp_channel_sel && (trig_hit || trig_pend_r)) ? ATR_WAIT : ATR_SAMPLE;
                    end
                end
                ATR_WAIT: begin
                    if (amp_evt) begin
                        state_r <= ATR_SAMPLE;
                    end
                end
                ATR_SAMPLE: begin
                    if (amp_channel_sel && amp_out_changed) begin
                        cnt_r <= 4'h0;
                    end else if (adc_clk_tick) begin
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r == atr_pkg::SAMPLE_CLKS - 4'h1) begin
                            state_r <= ATR_CONV;
                        end
                    end
                end
                ATR_CONV: begin
                    if (finish && trig_hit && tsel == atr_pkg::TRIG_FREE) begin
                        // free running goes straight back to sampling, no idle gap
                        cnt_r   <= 4'h0;
                        len_r   <= atr_pkg::CONV_CLKS;
                        state_r <= ATR_SAMPLE;
                    end else if (finish) begin
                        state_r <= ATR_IDLE;
                    end else if (adc_clk_tick) begin
                        cnt_r <= cnt_r + 4'h1;
                    end
                end
                default: state_r <= ATR_IDLE;
            endcase
        end
    end

    // start bit: written one sets, hardware clears on finish
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            start_r <= 1'b0;
        end else if (wr_a && reg_wdata[atr_pkg::CA_START]) begin
            start_r <= 1'b1;
        end else if (finish) begin
            start_r <= 1'b0;
        end
    end

    // done flag: set wins over either clear
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            done_r <= 1'b0;
        end else if (finish) begin
            done_r <= 1'b1;
        end else if (done_vector_ack || (wr_a && reg_wdata[atr_pkg::CA_DONE])) begin
            done_r <= 1'b0;
        end
    end

    // plain control registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_a_r   <= atr_pkg::RST_BYTE;
            ctrl_b_r   <= atr_pkg::RST_BYTE;
            dis_zero_r <= atr_pkg::RST_BYTE;
            dis_one_r  <= atr_pkg::RST_BYTE;
            amp_ctrl_r <= atr_pkg::RST_BYTE;
        end else begin
            if (wr_a) begin
                ctrl_a_r <= reg_wdata;
            end
            if (wr_hit(reg_addr, atr_pkg::OFS_CTRL_B, reg_wr)) begin
                ctrl_b_r <= reg_wdata & atr_pkg::CB_WMASK;
            end
            if (wr_hit(reg_addr, atr_pkg::OFS_DIS_ZERO, reg_wr)) begin
                dis_zero_r <= reg_wdata;
            end
            if (wr_hit(reg_addr, atr_pkg::OFS_DIS_ONE, reg_wr)) begin
                dis_one_r <= reg_wdata & atr_pkg::DIS_ONE_MASK;
            end
            if (wr_hit(reg_addr, atr_pkg::OFS_AMP_CTRL, reg_wr)) begin
                amp_ctrl_r <= reg_wdata;
            end
        end
    end

    // result capture and low/high read lock
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            result_r <= 10'h000;
            lock_r   <= 1'b0;
        end else begin
            // a low read in the finish cycle already locks the old word, so the new one is dropped
            if (finish && !lock_r && !(reg_rd && reg_addr == atr_pkg::OFS_RES_LOW)) begin
                result_r <= conv_data;
            end
            if (reg_rd && reg_addr == atr_pkg::OFS_RES_LOW) begin
                lock_r <= 1'b1;
            end else if (reg_rd && reg_addr == atr_pkg::OFS_RES_HIGH) begin
                lock_r <= 1'b0;
            end
        end
    end

    // layout follows left adjust at once, even mid conversion
    always_comb begin
        if (ctrl_a_r[atr_pkg::CA_LEFT]) begin
            res_hi = result_r[9:2];
            res_lo = {result_r[1:0], 6'h00};
        end else begin
            res_hi = {6'h00, result_r[9:8]};
            res_lo = result_r[7:0];
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                atr_pkg::OFS_CTRL_A:   reg_rdata <= {ctrl_a_r[7], start_r, ctrl_a_r[5], done_r, ctrl_a_r[3:0]};
                atr_pkg::OFS_CTRL_B:   reg_rdata <= ctrl_b_r;
                atr_pkg::OFS_RES_LOW:  reg_rdata <= res_lo;
                atr_pkg::OFS_RES_HIGH: reg_rdata <= res_hi;
                atr_pkg::OFS_DIS_ZERO: reg_rdata <= dis_zero_r;
                atr_pkg::OFS_DIS_ONE:  reg_rdata <= dis_one_r;
                atr_pkg::OFS_AMP_CTRL: reg_rdata <= amp_ctrl_r;
                default:               reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // port input sync then masking by disable bits
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pz_s1_r <= 8'h00;
            pz_s2_r <= 8'h00;
            po_s1_r <= 7'h00;
            po_s2_r <= 7'h00;
            port_read_zero    <= 8'h00;
            port_read_one     <= 7'h00;
            input_buf_disable <= 15'h0000;
        end else begin
            pz_s1_r <= port_in_zero;
            pz_s2_r <= pz_s1_r;
            po_s1_r <= port_in_one;
            po_s2_r <= po_s1_r;
            port_read_zero    <= pz_s2_r & ~dis_zero_r;
            port_read_one     <= po_s2_r & ~dis_one_r[6:0];
            input_buf_disable <= {dis_one_r[6:0], dis_zero_r};
        end
    end

    // registered status and analog control outputs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reference_pin_connect <= 1'b0;
            conv_busy        <= 1'b0;
            conv_sample      <= 1'b0;
            amp_phase_clock  <= 1'b0;
            amp_sample_pulse <= 1'b0;
        end else begin
            reference_pin_connect <= ctrl_b_r[atr_pkg::CB_REFPIN];
            conv_busy        <= state_r != ATR_IDLE;
            conv_sample      <= state_r == ATR_SAMPLE;
            amp_phase_clock  <= div_r[2];
            amp_sample_pulse <= amp_sync_r;
        end
    end
endmodule

// ### verilog/atr_pkg.sv
// package: register map, field positions and timing counts for the converter control block
package atr_pkg;
    // register offsets on the plain register port
    localparam logic [3:0] OFS_CTRL_A    = 4'h0;
    localparam logic [3:0] OFS_CTRL_B    = 4'h1;
    localparam logic [3:0] OFS_RES_LOW   = 4'h2;
    localparam logic [3:0] OFS_RES_HIGH  = 4'h3;
    localparam logic [3:0] OFS_DIS_ZERO  = 4'h4;
    localparam logic [3:0] OFS_DIS_ONE   = 4'h5;
    localparam logic [3:0] OFS_AMP_CTRL  = 4'h6;
    // control register a fields
    localparam int CA_START     = 6;
    localparam int CA_AUTO      = 5;
    localparam int CA_DONE      = 4;
    localparam int CA_LEFT      = 3;
    // control register b fields
    localparam int CB_REFPIN    = 5;
    localparam logic [7:0] CB_WMASK  = 8'hef;
    // amp control fields, then the disable one mask and the reset value
    localparam int AMP_EN       = 7;
    localparam int AMP_SRC_LO   = 0;
    localparam logic [7:0] DIS_ONE_MASK = 8'h7f;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // timing, in converter clocks, then trigger source codes
    localparam logic [3:0] CONV_CLKS     = 4'hd;
    localparam logic [3:0] CONV_CLKS_HI  = 4'he;
    localparam logic [3:0] SAMPLE_CLKS   = 4'h2;
    localparam logic [2:0] AMP_DIV_LAST  = 3'h7;
    localparam logic [2:0] AMP_SH_PHASE  = 3'h0;
    localparam logic [3:0] TRIG_FREE     = 4'h0;
    localparam logic [3:0] TRIG_PSTAGE0  = 4'h7;
    localparam logic [3:0] TRIG_COUNT    = 4'he;
endpackage
